// ### src/acr_pkg.sv
// Package: register map, field layout and types of the converter control block
package acr_pkg;
	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL_ZERO   = 8'h00;
	localparam logic [7:0] ADDR_CTRL_ONE    = 8'h04;
	localparam logic [7:0] ADDR_TRIG_SEL    = 8'h08;
	localparam logic [7:0] ADDR_RES_HIGH    = 8'h0C;
	localparam logic [7:0] ADDR_RES_LOW     = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h14;
	localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'h18;
	localparam logic [7:0] ADDR_IRQ_CLEAR   = 8'h1C;
	// ----------------------------------------------------------------
	// Field positions and masks
	// ----------------------------------------------------------------
	localparam int          BIT_CONV_ON      = 0;
	localparam int          BIT_CONV_GO      = 1;
	localparam int          BIT_JUSTIFY      = 7;
	localparam logic [7:0]  MASK_CTRL_ONE    = 8'hF3;
	localparam logic [7:0]  MASK_TRIG_SEL    = 8'h1F;
	localparam logic [7:0]  RST_CTRL_ONE     = 8'h00;
	localparam logic [7:0]  RST_TRIG_SEL     = 8'h00;
	localparam logic [4:0]  TRIG_CODE_COUNT  = 5'h13;
	localparam logic [1:0]  AXI_OKAY         = 2'b00;
	localparam logic [1:0]  AXI_SLVERR       = 2'b10;
	// Conversion length in conversion clock periods
	localparam logic [3:0]  CONV_TAD_COUNT   = 4'hB;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CLK_DIV2, CLK_DIV8, CLK_DIV32, CLK_RC_A, CLK_DIV4, CLK_DIV16, CLK_DIV64, CLK_RC_B
	} acr_clk_sel_t;
	typedef enum logic [1:0] {REF_SUPPLY, REF_RSVD, REF_PIN, REF_FIXED} acr_ref_sel_t;
	typedef struct packed {
		logic         result_justify_select;
		acr_clk_sel_t conv_clock_select;
		logic [1:0]   unused;
		acr_ref_sel_t pos_ref_select;
	} acr_ctrl_one_t;
	typedef struct packed {
		logic       valid;
		logic [9:0] conversion_result;
	} acr_result_t;
endpackage : acr_pkg

// ### src/acr_top.sv
// Converter control, trigger select and result registers behind AXI4-Lite
// Operation
// - Format one right-justifies, upper six zero
// - Format zero left-justifies, lower six zero
// - Codes 011 and 111 pick RC oscillator
// - Reference field picks supply, pin, fixed
// - Trigger field source starts on rising edge
// - Left layout: high 9..2, low 1..0
// - Right layout: high 9..8, low 7..0
// - Unimplemented bits read zero, ignore writes
// - Go bit holds while converting, self-clears
// - Enable bit gates the converter
//
// ----------------------------------------------------------------
// Register map, byte addresses, data in bits 7:0
// ----------------------------------------------------------------
// 0x00 control zero
//      bit 0 converter enable, read back as written
//      bit 1 go: writing one starts a conversion, reads busy
// 0x04 conv_control_one
//      bit 7 result layout, one right, zero left
//      bits 6:4 conversion clock code
//      bits 3:2 unimplemented, always read zero
//      bits 1:0 positive reference code
// 0x08 auto_trigger_select
//      bits 4:0 trigger source code, bits 7:5 read zero
// 0x0C result_high_byte, software may overwrite
// 0x10 result_low_byte, software may overwrite
// 0x14 interrupt status, bit 0 sticky, read only
// 0x18 interrupt enable, bit 0
// 0x1C interrupt clear, write one to bit 0, reads zero
// Any other address answers with a slave error and zero data.
//
// ----------------------------------------------------------------
// Bus timing
// ----------------------------------------------------------------
// Write address and data are captured independently; the
// response rises one cycle after both are held, and the
// register changes at that same edge.
// A read answers one cycle after its address is taken and
// holds its data until the master accepts it.
// Only byte lane zero matters; a write without it still gets
// a response but changes nothing.
//
// ----------------------------------------------------------------
// Conversion timing
// ----------------------------------------------------------------
// A start is a go write or a rising edge of the selected
// trigger, taken only while enabled and idle.
// Busy then stays up for a fixed number of conversion ticks;
// the sample input is captured at the last tick, the result
// bytes load one edge later and the flag sets with them.
// Trigger pins pass two flip-flops, so a pin edge reaches the
// sequencer about three edges later.
// Clearing the enable aborts a conversion without a result.
// The divider never stops, so the first tick after a clock
// code change may come early; only later periods are exact.
// The RC input is synchronised and only its rising edge is
// used; its period must exceed two system clock cycles.
`timescale 1ns/1ns
module acr_top
	import acr_pkg::*;
#(
	parameter int TRIG_COUNT = 19
) (
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_i,
	input  wire logic [7:0]            s_axi_awaddr_i,
	input  wire logic                  s_axi_awvalid_i,
	output logic                       s_axi_awready_o,
	input  wire logic [31:0]           s_axi_wdata_i,
	input  wire logic [3:0]            s_axi_wstrb_i,
	input  wire logic                  s_axi_wvalid_i,
	output logic                       s_axi_wready_o,
	output logic [1:0]                 s_axi_bresp_o,
	output logic                       s_axi_bvalid_o,
	input  wire logic                  s_axi_bready_i,
	input  wire logic [7:0]            s_axi_araddr_i,
	input  wire logic                  s_axi_arvalid_i,
	output logic                       s_axi_arready_o,
	output logic [31:0]                s_axi_rdata_o,
	output logic [1:0]                 s_axi_rresp_o,
	output logic                       s_axi_rvalid_o,
	input  wire logic                  s_axi_rready_i,
	input  wire logic [TRIG_COUNT-1:0] trig_src_i,
	input  wire logic                  rc_osc_i,
	input  wire logic [9:0]            sample_value_i,
	output logic                       converter_on_o,
	output acr_ref_sel_t               pos_ref_o,
	output logic                       conv_tick_o,
	output logic                       irq_o
);
	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	acr_ctrl_one_t               ctrl_one;
	logic [4:0]                  auto_trigger_code;
	logic                        converter_on;
	logic                        conv_busy;
	logic [7:0]                  result_high_byte;
	logic [7:0]                  result_low_byte;
	logic                        converter_irq_flag;
	logic                        irq_enable;
	logic [TRIG_COUNT-1:0]       trig_meta;
	logic [TRIG_COUNT-1:0]       trig_sync;
	logic [TRIG_COUNT-1:0]       trig_prev;
	logic [1:0]                  rc_sync;
	logic                        rc_prev;
	logic [5:0]                  div_cnt;
	logic [3:0]                  tad_cnt;
	acr_result_t                 done;
	logic                        wr_fire;
	logic                        rd_fire;
	logic                        aw_held;
	logic                        w_held;
	logic [7:0]                  wr_addr;
	logic [32:0]                 wr_data;
	logic                        wr_lane0;
	logic                        trig_rise;
	logic                        tad_tick;
	logic                        go_set;

	// Byte lane zero only: every register is eight bits wide
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == ADDR_CTRL_ZERO) || (a == ADDR_CTRL_ONE) || (a == ADDR_TRIG_SEL) ||
			(a == ADDR_RES_HIGH) || (a == ADDR_RES_LOW) || (a == ADDR_IRQ_STATUS) ||
			(a == ADDR_IRQ_ENABLE) || (a == ADDR_IRQ_CLEAR);
	endfunction : is_mapped

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	// Address and data are held independently so either may come first
	assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
	assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
	assign wr_fire  = aw_held && w_held && !s_axi_bvalid_o;
	assign wr_lane0 = wr_fire && wr_data[32] == 1'b0;
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			aw_held        <= 1'b0;
			w_held         <= 1'b0;
			wr_addr        <= 8'h00;
			wr_data        <= 33'h0_0000_0000;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= AXI_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_held <= 1'b1;
				wr_addr <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_held  <= 1'b1;
				wr_data <= {!s_axi_wstrb_i[0], s_axi_wdata_i};
			end
			if (wr_fire) begin
				aw_held        <= 1'b0;
				w_held         <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= is_mapped(wr_addr) ? AXI_OKAY : AXI_SLVERR;
			end else if (s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	assign s_axi_arready_o = !s_axi_rvalid_o;
	assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h0000_0000;
			s_axi_rresp_o  <= AXI_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o  <= is_mapped(s_axi_araddr_i) ? AXI_OKAY : AXI_SLVERR;
			case (s_axi_araddr_i)
				ADDR_CTRL_ZERO:  s_axi_rdata_o <= {30'h0000_0000, conv_busy, converter_on};
				ADDR_CTRL_ONE:   s_axi_rdata_o <= {24'h00_0000, ctrl_one};
				ADDR_TRIG_SEL:   s_axi_rdata_o <= {27'h000_0000, auto_trigger_code};
				ADDR_RES_HIGH:   s_axi_rdata_o <= {24'h00_0000, result_high_byte};
				ADDR_RES_LOW:    s_axi_rdata_o <= {24'h00_0000, result_low_byte};
				ADDR_IRQ_STATUS: s_axi_rdata_o <= {31'h0000_0000, converter_irq_flag};
				ADDR_IRQ_ENABLE: s_axi_rdata_o <= {31'h0000_0000, irq_enable};
				default:         s_axi_rdata_o <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// Unimplemented positions are masked on write so they always read zero
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ctrl_one          <= RST_CTRL_ONE;
			auto_trigger_code <= RST_TRIG_SEL[4:0];
			irq_enable        <= 1'b0;
		end else if (wr_lane0) begin
			case (wr_addr)
				ADDR_CTRL_ONE:   ctrl_one          <= wr_data[7:0] & MASK_CTRL_ONE;
				ADDR_TRIG_SEL:   auto_trigger_code <= wr_data[4:0];
				ADDR_IRQ_ENABLE: irq_enable        <= wr_data[0];
				default: ;
			endcase
		end
	end

	// Converter enable; dropping it aborts the conversion
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			converter_on <= 1'b0;
		end else if (wr_lane0 && wr_addr == ADDR_CTRL_ZERO) begin
			converter_on <= wr_data[BIT_CONV_ON];
		end
	end
	assign converter_on_o = converter_on;
	assign pos_ref_o      = ctrl_one.pos_ref_select;

	// ----------------------------------------------------------------
	// Trigger synchronisers and edge detect
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			trig_meta <= '0;
			trig_sync <= '0;
			trig_prev <= '0;
			rc_sync   <= 2'b00;
			rc_prev   <= 1'b0;
		end else begin
			trig_meta <= trig_src_i;
			trig_sync <= trig_meta;
			trig_prev <= trig_sync;
			rc_sync   <= {rc_sync[0], rc_osc_i};
			rc_prev   <= rc_sync[1];
		end
	end
	// Reserved codes select nothing, so they never start a conversion
	assign trig_rise = (auto_trigger_code < TRIG_CODE_COUNT) &&
		trig_sync[auto_trigger_code] && !trig_prev[auto_trigger_code];

	// ----------------------------------------------------------------
	// Conversion clock
	// ----------------------------------------------------------------
	// Free-running divider; each divider code taps the matching terminal count, RC codes use the RC edge
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			div_cnt <= 6'h00;
		end else begin
			div_cnt <= div_cnt + 6'h01;
		end
	end
	always_comb begin
		case (ctrl_one.conv_clock_select)
			CLK_DIV2:  tad_tick = div_cnt[0]   == 1'b1;
			CLK_DIV4:  tad_tick = div_cnt[1:0] == 2'h3;
			CLK_DIV8:  tad_tick = div_cnt[2:0] == 3'h7;
			CLK_DIV16: tad_tick = div_cnt[3:0] == 4'hF;
			CLK_DIV32: tad_tick = div_cnt[4:0] == 5'h1F;
			CLK_DIV64: tad_tick = div_cnt      == 6'h3F;
			default:   tad_tick = rc_sync[1] && !rc_prev;
		endcase
	end
	assign conv_tick_o = tad_tick;

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	assign go_set = converter_on &&
		((wr_lane0 && wr_addr == ADDR_CTRL_ZERO && wr_data[BIT_CONV_GO]) || trig_rise);
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			conv_busy <= 1'b0;
			tad_cnt   <= 4'h0;
			done      <= '0;
		end else begin
			done.valid <= 1'b0;
			if (!converter_on) begin
				conv_busy <= 1'b0;
			end else if (!conv_busy && go_set) begin
				conv_busy <= 1'b1;
				tad_cnt   <= 4'h0;
			end else if (conv_busy && tad_tick) begin
				if (tad_cnt == CONV_TAD_COUNT - 4'h1) begin
					conv_busy              <= 1'b0;
					done.valid             <= 1'b1;
					done.conversion_result <= sample_value_i;
				end else begin
					tad_cnt <= tad_cnt + 4'h1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Result registers
	// ----------------------------------------------------------------
	// Software may overwrite the bytes; a completed conversion replaces them
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			result_high_byte <= 8'h00;
			result_low_byte  <= 8'h00;
		end else if (done.valid) begin
			if (ctrl_one.result_justify_select) begin
				result_high_byte <= {6'h00, done.conversion_result[9:8]};
				result_low_byte  <= done.conversion_result[7:0];
			end else begin
				result_high_byte <= done.conversion_result[9:2];
				result_low_byte  <= {done.conversion_result[1:0], 6'h00};
			end
		end else if (wr_lane0 && wr_addr == ADDR_RES_HIGH) begin
			result_high_byte <= wr_data[7:0];
		end else if (wr_lane0 && wr_addr == ADDR_RES_LOW) begin
			result_low_byte <= wr_data[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Interrupt
	// ----------------------------------------------------------------
	// Completion wins over a clear in the same cycle so no event is lost
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			converter_irq_flag <= 1'b0;
		end else if (done.valid) begin
			converter_irq_flag <= 1'b1;
		end else if (wr_lane0 && wr_addr == ADDR_IRQ_CLEAR && wr_data[0]) begin
			converter_irq_flag <= 1'b0;
		end
	end
	assign irq_o = converter_irq_flag && irq_enable;

endmodule : acr_top

// ### verification/acr_top_asserts.sv
// Port-level checker for the converter control and result register block
`timescale 1ns/1ns
module acr_top_asserts
	import acr_pkg::*;
(
	input wire logic         core_clk_i,
	input wire logic         rst_i,
	input wire logic [7:0]   s_axi_awaddr_i,
	input wire logic         s_axi_awvalid_i,
	input wire logic         s_axi_awready_o,
	input wire logic [31:0]  s_axi_wdata_i,
	input wire logic [3:0]   s_axi_wstrb_i,
	input wire logic         s_axi_wvalid_i,
	input wire logic         s_axi_wready_o,
	input wire logic         s_axi_bvalid_o,
	input wire logic         s_axi_bready_i,
	input wire logic [7:0]   s_axi_araddr_i,
	input wire logic         s_axi_arvalid_i,
	input wire logic         s_axi_arready_o,
	input wire logic [31:0]  s_axi_rdata_o,
	input wire logic [1:0]   s_axi_rresp_o,
	input wire logic         s_axi_rvalid_o,
	input wire logic         s_axi_rready_i,
	input wire logic         converter_on_o,
	input wire acr_ref_sel_t pos_ref_o,
	input wire logic         conv_tick_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// Taken write and read requests, with the data fields the checks follow
	wire       wr_take = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o && s_axi_wstrb_i[0];
	wire       rd_take = s_axi_arvalid_i && s_axi_arready_o;
	wire [1:0] wd_ref  = s_axi_wdata_i[1:0];
	wire       wd_on   = s_axi_wdata_i[BIT_CONV_ON];
	chk_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
		else $error("write response dropped before bready");
	chk_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data changed before rready");
	chk_read_busy: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read address accepted while a read is pending");
	chk_tick_gap: assert property (conv_tick_o |=> !conv_tick_o)
		else $error("conversion ticks closer than two cycles");
	chk_ctrl_mask: assert property (rd_take && s_axi_araddr_i == ADDR_CTRL_ONE |=> (s_axi_rdata_o & ~32'h0000_00F3) == '0)
		else $error("unused control bits read nonzero");
	chk_trig_mask: assert property (rd_take && s_axi_araddr_i == ADDR_TRIG_SEL |=> (s_axi_rdata_o & ~32'h0000_001F) == '0)
		else $error("unused trigger bits read nonzero");
	chk_ref_follow: assert property (wr_take && s_axi_awaddr_i == ADDR_CTRL_ONE |-> ##2 pos_ref_o == $past(wd_ref, 2))
		else $error("reference output does not follow its field");
	chk_enable_follow: assert property (wr_take && s_axi_awaddr_i == ADDR_CTRL_ZERO |-> ##2 converter_on_o == $past(wd_on, 2))
		else $error("enable output does not follow its bit");
	chk_unmapped_read: assert property (rd_take && s_axi_araddr_i > ADDR_IRQ_CLEAR |=> s_axi_rresp_o == AXI_SLVERR && s_axi_rdata_o == '0)
		else $error("unmapped read not refused");
endmodule : acr_top_asserts

bind acr_top acr_top_asserts i_acr_top_asserts (.core_clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
	.s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
	.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
	.converter_on_o, .pos_ref_o, .conv_tick_o);

// ### verification/acr_top_tb_top.sv
// Self-checking bench for the converter control and result register block
`timescale 1ns/1ns
module acr_top_tb_top
	import acr_pkg::*;
;
	logic core_clk_i = 0, rst_i = 1, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
	logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, rc_osc_i = 0;
	logic [7:0]  s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
	logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o, seed = 32'h4ad5_1272;
	logic [3:0]  s_axi_wstrb_i = '0;
	logic [18:0] trig_src_i = '0;
	logic [9:0]  sample_value_i = '0;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, converter_on_o, conv_tick_o, irq_o;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
	acr_ref_sel_t pos_ref_o;
	logic [33:0] rq[$];
	logic [1:0]  wq[$];
	int          failures = 0, compares = 0, rcn = 0;
	int          gaps[8] = '{2, 8, 32, 10, 4, 16, 64, 10};
	acr_top i_acr_top (.core_clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
		.s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
		.s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
		.s_axi_rready_i, .trig_src_i, .rc_osc_i, .sample_value_i, .converter_on_o, .pos_ref_o, .conv_tick_o, .irq_o);
	// 20 MHz system clock
	always #25 core_clk_i = ~core_clk_i;
	// RC oscillator stand-in: rising edge every ten system cycles
	always @(posedge core_clk_i) begin
		rcn <= (rcn == 4) ? 0 : rcn + 1;
		if (rcn == 4) rc_osc_i <= ~rc_osc_i;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	task automatic cmp(input string s, input logic [33:0] e, input logic [33:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask : cmp
	task automatic end_sim;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_sim
	// Response monitor: an empty queue yields an unknown note, so a stray answer fails
	always @(posedge core_clk_i) begin
		if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i) cmp("read", rq.size() ? rq.pop_front() : 'x, {s_axi_rresp_o, s_axi_rdata_o});
		if (s_axi_bvalid_o === 1'b1 && s_axi_bready_i) cmp("bresp", wq.size() ? wq.pop_front() : 'x, s_axi_bresp_o);
	end
	// AXI4-Lite write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n = 0;
		wq.push_back(AXI_OKAY);
		@(posedge core_clk_i);
		{s_axi_awaddr_i, s_axi_wdata_i, s_axi_wstrb_i} <= {a, 24'h00_0000, d, 4'hF};
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
		do begin
			@(posedge core_clk_i);
			n++;
			if (s_axi_awready_o) s_axi_awvalid_i <= 0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 0;
		end while (s_axi_bvalid_o !== 1'b1 && n < 100);
		s_axi_bready_i <= 0;
	endtask : wr
	// AXI4-Lite read, expected word noted before the request goes out
	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = AXI_OKAY);
		int n = 0;
		rq.push_back({r, 24'h00_0000, d});
		@(posedge core_clk_i);
		{s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i} <= {a, 2'h3};
		do begin
			@(posedge core_clk_i);
			n++;
			if (s_axi_arready_o) s_axi_arvalid_i <= 0;
		end while (s_axi_rvalid_o !== 1'b1 && n < 100);
		s_axi_rready_i <= 0;
	endtask : rd
	// Skip the first tick after a code change, then count one full period
	task automatic gap(input int e);
		int n = 0;
		repeat (4) @(posedge core_clk_i);
		while (conv_tick_o !== 1'b1 && n < 200) begin @(posedge core_clk_i); n++; end
		n = 0;
		do begin @(posedge core_clk_i); n++; end while (conv_tick_o !== 1'b1 && n < 200);
		cmp("tick gap", 34'(e), 34'(n));
	endtask : gap
	task automatic wirq(input logic e);
		int n = 0;
		while (irq_o !== e && n < 300) begin @(posedge core_clk_i); n++; end
		cmp("irq", e, irq_o);
	endtask : wirq
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge core_clk_i);
		rst_i <= 0;
		rd(ADDR_CTRL_ONE, 8'h00);
		wr(ADDR_CTRL_ONE, 8'hFF);
		rd(ADDR_CTRL_ONE, 8'hF3);
		wr(ADDR_TRIG_SEL, 8'hFF);
		rd(ADDR_TRIG_SEL, 8'h1F);
		rd(8'h20, 8'h00, AXI_SLVERR);
		foreach (gaps[c]) begin
			wr(ADDR_CTRL_ONE, {1'b0, c[2:0], 4'h2});
			cmp("ref", 34'(REF_PIN), 34'(pos_ref_o));
		end
		wr(ADDR_CTRL_ZERO, 8'h01);
		foreach (gaps[c]) begin
			wr(ADDR_CTRL_ONE, {1'b0, c[2:0], 4'h0});
			gap(gaps[c]);
		end
		wr(ADDR_IRQ_ENABLE, 8'h01);
		// Software start in both result layouts, random sample each time
		for (int j = 0; j < 2; j++) begin
			seed = xs(seed);
			sample_value_i <= seed[9:0];
			wr(ADDR_CTRL_ONE, {j[0], 7'h00});
			wr(ADDR_CTRL_ZERO, 8'h03);
			rd(ADDR_CTRL_ZERO, 8'h03);
			wirq(1);
			rd(ADDR_CTRL_ZERO, 8'h01);
			rd(ADDR_IRQ_STATUS, 8'h01);
			rd(ADDR_RES_HIGH, j ? {6'h00, seed[9:8]} : seed[9:2]);
			rd(ADDR_RES_LOW, j ? seed[7:0] : {seed[1:0], 6'h00});
			wr(ADDR_IRQ_CLEAR, 8'h01);
			wirq(0);
		end
		// Hardware trigger on a random source, then masking of the flag
		seed = xs(seed);
		wr(ADDR_TRIG_SEL, 8'(seed % 19));
		trig_src_i[seed % 19] <= 1'b1;
		wirq(1);
		wr(ADDR_IRQ_ENABLE, 8'h00);
		wirq(0);
		rd(ADDR_IRQ_STATUS, 8'h01);
		wr(ADDR_IRQ_ENABLE, 8'h01);
		wirq(1);
		wr(ADDR_IRQ_CLEAR, 8'h01);
		trig_src_i <= '0;
		wr(ADDR_TRIG_SEL, 8'h13);
		trig_src_i <= '1;
		repeat (100) @(posedge core_clk_i);
		cmp("irq", 0, irq_o);
		end_sim();
	end
	// Watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge core_clk_i);
		failures++;
		end_sim();
	end
endmodule : acr_top_tb_top
